// file: bench/adsg_alarm_group_test.sv
// Self-checking bench for the alarm group: registers, clock loss, line AIS,
// FIFO slips, external pins and interrupts.
// Assumes the package, the design and the far-side model are compiled first.
`timescale 1ns/1ps

module adsg_alarm_group_test;
    import adsg_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    adsg_pins_s pins;
    adsg_fifo_s fifo = '0;
    logic vld = 1'b0;
    logic rx_bit = 1'b1;
    logic fstart = 1'b0;
    logic floss = 1'b0;
    logic ais_alarm = 1'b0;
    logic recenter, rdi, ais_gen, soft_int, irq;
    logic [3:0] stop = 4'h0;
    logic [2:0] alarm = 3'h0;
    int mismatches = 0;
    int checked = 0;

    always #10 ref_clk = ~ref_clk;

    adsg_far_model adsg_far_model_i (.clk_i(ref_clk), .stop_i(stop), .alarm_i(alarm),
        .pins_o(pins));

    adsg_alarm_group adsg_alarm_group_i (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .PINS_I(pins), .FIFO_I(fifo), .RX_BIT_VLD_I(vld), .RX_BIT_I(rx_bit),
        .FRAME_START_I(fstart), .FRAME_LOSS_I(floss), .RX_AIS_ALARM_I(ais_alarm),
        .FIFO_RECENTER_O(recenter), .PATH_RDI_O(rdi), .RX_AIS_GEN_O(ais_gen),
        .SOFT_INT_O(soft_int), .IRQ_O(irq));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // One 16-bit frame period with nz leading zeros
    task automatic frame(input int nz);
        for (int k = 0; k < 16; k++) begin
            @(posedge ref_clk);
            fstart <= (k == 0);
            vld <= 1'b1;
            rx_bit <= (k >= nz);
        end
    endtask

    // Third frame start closes the second period under test
    task automatic ais_seq(input int n1, input int n2, input logic [7:0] exp);
        frame(n1);
        frame(n2);
        frame(16);
        rd_chk(8'h22, exp, "line ais");
    endtask

    task automatic t_regs();
        logic [7:0] adr [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h31, 8'h32, 8'h33,
            8'h34, 8'h40};
        foreach (adr[i]) rd_chk(adr[i], 8'h00, "reset value");
        wr_reg(8'h24, 8'hff);
        rd_chk(8'h24, 8'h00, "status read-only");
        wr_reg(8'h34, 8'h3f);
        rd_chk(8'h34, 8'h3f, "control readback");
        wr_reg(8'h34, 8'h00);
        $display("t_regs done");
    endtask

    task automatic t_loc();
        stop <= 4'h4;
        cyc(40);
        rd_chk(8'h24, 8'h00, "add loss outside add timing");
        @(posedge ref_clk);
        stop <= 4'h0;
        wr_reg(8'h34, 8'h04);
        for (int j = 3; j >= 0; j--) begin
            @(posedge ref_clk);
            stop <= 4'h1 << j;
            cyc(6);
            rd_chk(8'h24, 8'h00, "loss too early");
            cyc(30);
            rd_chk(8'h24, 8'h10 << j, "loss flagged");
            @(posedge ref_clk);
            stop <= 4'h0;
            cyc(8);
            rd_chk(8'h24, 8'h00, "loss recovered");
        end
        rd_chk(8'h25, 8'hf0, "loss latched");
        wr_reg(8'h25, 8'hf0);
        rd_chk(8'h25, 8'h00, "latch cleared");
        wr_reg(8'h34, 8'h00);
        $display("t_loc done");
    endtask

    task automatic t_fifo_irq();
        wr_reg(8'h32, 8'h08);
        wr_reg(8'h33, 8'h80);
        #1;
        chk("soft int idle", 8'h00, {7'h0, soft_int});
        for (int k = 0; k < 2; k++) begin
            // Slips only on demand: leak rate assumed small enough otherwise
            @(posedge ref_clk);
            fifo <= adsg_fifo_s'(2'b01 << k);
            @(posedge ref_clk);
            fifo <= '0;
            #1;
            chk("recenter", 8'h01, {7'h0, recenter});
            chk("soft int", 8'h01, {7'h0, soft_int});
            chk("irq", 8'h01, {7'h0, irq});
            rd_chk(8'h25, 8'h08, "fifo latched");
            chk("recenter once", 8'h00, {7'h0, recenter});
            wr_reg(8'h25, 8'h08);
            #1;
            chk("soft int cleared", 8'h00, {7'h0, soft_int});
        end
        @(posedge ref_clk);
        fifo <= 2'b10;
        @(posedge ref_clk);
        fifo <= '0;
        wr_reg(8'h33, 8'h00);
        #1;
        chk("irq disabled", 8'h00, {7'h0, irq});
        rd_chk(8'h26, 8'h80, "soft int reg");
        wr_reg(8'h32, 8'h00);
        wr_reg(8'h25, 8'hff);
        $display("t_fifo_irq done");
    endtask

    task automatic t_ext();
        for (int j = 2; j >= 0; j--) begin
            wr_reg(8'h34, (j == 2) ? 8'h18 : 8'h20);
            alarm <= 3'h1 << j;
            cyc(5);
            chk("path rdi", 8'h01, {7'h0, rdi});
            chk("rx ais gen", (j == 2) ? 8'h00 : 8'h01, {7'h0, ais_gen});
            rd_chk(8'h24, 8'h01 << j, "ext status");
            // Half of the RDI enable pair, or that pair without ext_act_en, must not be enough
            wr_reg(8'h34, (j == 2) ? 8'h08 : 8'h18);
            cyc(4);
            chk("path rdi gated", 8'h00, {7'h0, rdi});
            @(posedge ref_clk);
            alarm <= 3'h0;
            cyc(5);
        end
        wr_reg(8'h34, 8'h00);
        wr_reg(8'h25, 8'hff);
        $display("t_ext done");
    endtask

    task automatic t_ais();
        ais_seq(5, 5, 8'h01);
        ais_seq(5, 9, 8'h01);
        ais_seq(6, 6, 8'h00);
        ais_seq(5, 6, 8'h00);
        wr_reg(8'h34, 8'h02);
        ais_seq(5, 5, 8'h00);
        @(posedge ref_clk);
        floss <= 1'b1;
        ais_seq(5, 5, 8'h01);
        @(posedge ref_clk);
        floss <= 1'b0;
        cyc(3);
        rd_chk(8'h22, 8'h00, "aligned clears ais");
        @(posedge ref_clk);
        floss <= 1'b1;
        ais_seq(5, 5, 8'h01);
        ais_seq(6, 6, 8'h00);
        @(posedge ref_clk);
        floss <= 1'b0;
        wr_reg(8'h34, 8'h01);
        ais_alarm <= 1'b1;
        ais_seq(5, 5, 8'h00);
        @(posedge ref_clk);
        ais_alarm <= 1'b0;
        ais_seq(5, 5, 8'h01);
        wr_reg(8'h34, 8'h00);
        ais_alarm <= 1'b1;
        // Clear first, so the declare below is a fresh detection
        ais_seq(6, 6, 8'h00);
        ais_seq(5, 5, 8'h01);
        @(posedge ref_clk);
        ais_alarm <= 1'b0;
        $display("t_ais done");
    endtask

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        cyc(4);
        t_regs();
        t_loc();
        t_fifo_irq();
        t_ext();
        t_ais();
        test_done();
    end

    // Whole run needs under 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        $display("[ERR] watchdog expected finish seen hang");
        test_done();
    end
endmodule // adsg_alarm_group_test

// file: bench/adsg_far_model.sv
// Far-side model: the four monitored line and bus clocks and the alarm pins.
// Assumes clk_i is the RAM clock; each clock toggles every 4 RAM cycles.
`timescale 1ns/1ps

module adsg_far_model (
    input wire logic clk_i,
    input wire logic [3:0] stop_i,
    input wire logic [2:0] alarm_i,
    output adsg_pkg::adsg_pins_s pins_o
);
    import adsg_pkg::*;

    logic [1:0] div_q;
    logic [3:0] clk_q;

    initial begin
        div_q = 2'h0;
        clk_q = 4'h0;
    end

    // Slow enough to be seen toggling after the two-stage sync
    always @(posedge clk_i) begin
        div_q <= div_q + 2'h1;
        // A dead source holds its last level
        if (div_q == 2'h3) begin
            clk_q <= clk_q ^ ~stop_i;
        end
    end

    assign pins_o = {clk_q, alarm_i};
endmodule // adsg_far_model

// file: logic/adsg_alarm_group.sv
// Alarm detection and status group: line AIS, four loss-of-clock monitors,
// first-stage FIFO error and three external alarm pins, with latched bits,
// masks and interrupts. Assumes all logic runs on the RAM clock REF_CLK_I;
// monitored clocks and alarm pins are asynchronous, the rest is synchronous.
`timescale 1ns/1ps
`include "adsg_consts.svh"

module adsg_alarm_group (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire adsg_pkg::adsg_pins_s PINS_I,
    input wire adsg_pkg::adsg_fifo_s FIFO_I,
    input wire logic RX_BIT_VLD_I,
    input wire logic RX_BIT_I,
    input wire logic FRAME_START_I,
    input wire logic FRAME_LOSS_I,
    input wire logic RX_AIS_ALARM_I,
    output logic FIFO_RECENTER_O,
    output logic PATH_RDI_O,
    output logic RX_AIS_GEN_O,
    output logic SOFT_INT_O,
    output logic IRQ_O
);
    import adsg_pkg::*;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    function automatic logic [5:0] sat_inc6(input logic [5:0] v);
        sat_inc6 = (v == 6'h3f) ? v : v + 6'h01;
    endfunction

    function automatic logic [2:0] sat_inc3(input logic [2:0] v);
        sat_inc3 = (v == 3'h7) ? v : v + 3'h1;
    endfunction

    // Synchronisers: stage 1 is read only by stage 2
    adsg_pins_s sync1_q;
    adsg_pins_s sync2_q;
    adsg_pins_s sync3_q;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= PINS_I;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    a_sync_delay: assert property ($past(RST_N_I) && $past(RST_N_I, 2)
        |-> sync2_q.network_alarm_pin == $past(PINS_I.network_alarm_pin, 2))
        else $error("network alarm pin not synchronised in two stages");

    // Control registers
    logic [7:0] ctrl_q;
    logic [7:0] mask_b_q;
    logic [7:0] mask_c_q;
    logic hard_en_q;
    logic bsais_en;
    logic fdais_en;
    logic add_timing;
    logic xrdi_en;
    logic rdi_en;
    logic ext_act_en;

    assign bsais_en = ctrl_q[`ADSG_CTRL_BSAIS];
    assign fdais_en = ctrl_q[`ADSG_CTRL_FDAIS];
    assign add_timing = ctrl_q[`ADSG_CTRL_ADD_TIMING];
    assign xrdi_en = ctrl_q[`ADSG_CTRL_XRDI];
    assign rdi_en = ctrl_q[`ADSG_CTRL_RDI];
    assign ext_act_en = ctrl_q[`ADSG_CTRL_EXT_ACT];

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ctrl_q <= `ADSG_RST_BYTE;
            mask_b_q <= `ADSG_RST_BYTE;
            mask_c_q <= `ADSG_RST_BYTE;
            hard_en_q <= 1'b0;
        end else if (WR_I) begin
            unique case (ADDR_I)
                `ADSG_ADDR_CTRL: begin
                    ctrl_q <= {2'h0, WDATA_I[5:0]};
                end
                `ADSG_ADDR_MASK_B: begin
                    mask_b_q <= {7'h00, WDATA_I[`ADSG_B_LINE_AIS]};
                end
                `ADSG_ADDR_MASK_C: begin
                    mask_c_q <= WDATA_I;
                end
                `ADSG_ADDR_HARD_EN: begin
                    hard_en_q <= WDATA_I[`ADSG_INT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // External alarm pins act for as long as they stay high
    logic ext_ais_req;

    assign ext_ais_req = ext_act_en
        && (sync2_q.external_sts_alarm_pin || sync2_q.external_path_ais_pin);

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            PATH_RDI_O <= 1'b0;
            RX_AIS_GEN_O <= 1'b0;
        end else begin
            PATH_RDI_O <= (sync2_q.network_alarm_pin && xrdi_en && rdi_en)
                || ext_ais_req;
            RX_AIS_GEN_O <= ext_ais_req || RX_AIS_ALARM_I;
        end
    end

    a_net_rdi: assert property (sync2_q.network_alarm_pin && xrdi_en && rdi_en |=> PATH_RDI_O)
        else $error("network alarm did not send path RDI");
    a_ext_ais_gen: assert property (ext_act_en && sync2_q.external_path_ais_pin
        |=> RX_AIS_GEN_O && PATH_RDI_O)
        else $error("path AIS pin did not generate AIS and RDI");
    a_sts_ais_gen: assert property (ext_act_en && sync2_q.external_sts_alarm_pin
        |=> RX_AIS_GEN_O && PATH_RDI_O)
        else $error("STS alarm pin did not generate AIS and RDI");

    // Loss-of-clock monitors: 0 tx line, 1 add bus, 2 drop bus, 3 rx line
    logic [3:0] clk_now;
    logic [3:0] clk_edge;
    logic [3:0] loc_flag_q;
    logic [5:0] loc_cnt_q [4];
    logic [5:0] loc_limit [4];

    assign clk_now = {sync2_q.rx_line_clock, sync2_q.drop_bus_clock,
        sync2_q.add_bus_clock, sync2_q.tx_line_clock};
    assign clk_edge = clk_now ^ {sync3_q.rx_line_clock, sync3_q.drop_bus_clock,
        sync3_q.add_bus_clock, sync3_q.tx_line_clock};
    assign loc_limit[0] = `ADSG_LOC_LIMIT_BUS;
    assign loc_limit[1] = `ADSG_LOC_LIMIT_BUS;
    assign loc_limit[2] = `ADSG_LOC_LIMIT_BUS;
    assign loc_limit[3] = `ADSG_LOC_LIMIT_RX;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < 4; i++) begin
                loc_cnt_q[i] <= 6'h00;
                loc_flag_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (clk_edge[i]) begin
                    loc_cnt_q[i] <= 6'h00;
                    loc_flag_q[i] <= 1'b0;
                end else begin
                    loc_cnt_q[i] <= sat_inc6(loc_cnt_q[i]);
                    if (sat_inc6(loc_cnt_q[i]) >= loc_limit[i]) begin
                        loc_flag_q[i] <= 1'b1;
                    end
                end
            end
            // Add bus clock is only meaningful in add bus timing
            if (!add_timing) begin
                loc_flag_q[1] <= 1'b0;
            end
        end
    end

    a_tx_loc_raise: assert property (loc_cnt_q[0] >= `ADSG_LOC_LIMIT_BUS |-> loc_flag_q[0])
        else $error("tx line clock loss not flagged");
    a_rx_loc_raise: assert property (loc_cnt_q[3] >= `ADSG_LOC_LIMIT_RX |-> loc_flag_q[3])
        else $error("rx line clock loss not flagged");
    a_loc_recover: assert property (loc_flag_q[2] && clk_edge[2] |=> !loc_flag_q[2])
        else $error("drop bus clock loss not cleared on transition");
    a_add_loc_mode: assert property (!add_timing |=> !loc_flag_q[1])
        else $error("add bus loss flagged outside add bus timing");

    // First-stage FIFO slip: flag and ask for a recenter, nothing more
    logic fifo_err;

    assign fifo_err = FIFO_I.fifo_overflow || FIFO_I.fifo_underflow;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            FIFO_RECENTER_O <= 1'b0;
        end else begin
            FIFO_RECENTER_O <= fifo_err;
        end
    end

    // Line AIS detector: zero count per frame period, two-frame history
    adsg_ais_e ais_state_q;
    logic [2:0] zero_cnt_q;
    logic prev_low_q;
    logic frame_low;
    logic ais_enable;
    logic bit_zero;

    assign bit_zero = RX_BIT_VLD_I && !RX_BIT_I;
    assign frame_low = zero_cnt_q <= `ADSG_AIS_MAX_ZEROS;
    assign ais_enable = !bsais_en || !RX_AIS_GEN_O;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            zero_cnt_q <= 3'h0;
            prev_low_q <= 1'b0;
        end else if (FRAME_START_I) begin
            zero_cnt_q <= bit_zero ? 3'h1 : 3'h0;
            prev_low_q <= frame_low;
        end else if (bit_zero) begin
            zero_cnt_q <= sat_inc3(zero_cnt_q);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ais_state_q <= AIS_OFF;
        end else if (!ais_enable) begin
            ais_state_q <= AIS_OFF;
        end else begin
            unique case (ais_state_q)
                AIS_OFF: begin
                    ais_state_q <= AIS_CLEAR;
                end
                AIS_CLEAR: begin
                    if (FRAME_START_I && frame_low && prev_low_q
                        && (!fdais_en || FRAME_LOSS_I)) begin
                        ais_state_q <= AIS_DECLARED;
                    end
                end
                AIS_DECLARED: begin
                    if (fdais_en && !FRAME_LOSS_I) begin
                        ais_state_q <= AIS_CLEAR;
                    end else if (FRAME_START_I && !frame_low && !prev_low_q) begin
                        ais_state_q <= AIS_CLEAR;
                    end
                end
                default: begin
                    ais_state_q <= AIS_OFF;
                end
            endcase
        end
    end

    logic line_ais;

    assign line_ais = ais_state_q == AIS_DECLARED;

    a_ais_declare: assert property (ais_enable && ais_state_q == AIS_CLEAR && FRAME_START_I
        && frame_low && prev_low_q && !fdais_en |=> line_ais)
        else $error("line AIS not declared after two low-zero frames");
    a_ais_recover: assert property (line_ais && FRAME_START_I && !frame_low && !prev_low_q
        |=> !line_ais)
        else $error("line AIS not cleared after two busy frames");
    a_ais_fd_gate: assert property (fdais_en && !FRAME_LOSS_I |=> !line_ais)
        else $error("frame mode AIS held while aligned");
    a_ais_bs_gate: assert property (bsais_en && RX_AIS_GEN_O |=> !line_ais)
        else $error("line AIS detected while generating AIS");

    // Live status, sticky latches (set wins over write-one-clear)
    logic [7:0] stat_b;
    logic [7:0] stat_c;
    logic [7:0] latch_b_q;
    logic [7:0] latch_c_q;
    logic clr_b;
    logic clr_c;

    assign stat_b = {7'h00, line_ais};
    assign stat_c = {loc_flag_q[0], loc_flag_q[1], loc_flag_q[2], loc_flag_q[3], fifo_err,
        sync2_q.network_alarm_pin, sync2_q.external_sts_alarm_pin,
        sync2_q.external_path_ais_pin};
    assign clr_b = WR_I && (ADDR_I == `ADSG_ADDR_LATCH_B);
    assign clr_c = WR_I && (ADDR_I == `ADSG_ADDR_LATCH_C);

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            latch_b_q <= `ADSG_RST_BYTE;
            latch_c_q <= `ADSG_RST_BYTE;
        end else begin
            latch_b_q <= (latch_b_q & ~(clr_b ? WDATA_I : 8'h00)) | stat_b;
            latch_c_q <= (latch_c_q & ~(clr_c ? WDATA_I : 8'h00)) | stat_c;
        end
    end

    a_fifo_flag: assert property (fifo_err |=> FIFO_RECENTER_O && latch_c_q[`ADSG_C_FIFO_ERR])
        else $error("FIFO slip not latched or not recentered");

    // Interrupts
    assign SOFT_INT_O = |{latch_b_q & mask_b_q, latch_c_q & mask_c_q};
    assign IRQ_O = SOFT_INT_O && hard_en_q;

    a_hard_irq: assert property (hard_en_q && |(latch_c_q & mask_c_q) |-> IRQ_O)
        else $error("masked latched alarm did not raise interrupt");

    // Read port: data one cycle after the strobe, unmapped reads as zero
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            unique case (ADDR_I)
                `ADSG_ADDR_STAT_B: RDATA_O <= stat_b;
                `ADSG_ADDR_LATCH_B: RDATA_O <= latch_b_q;
                `ADSG_ADDR_STAT_C: RDATA_O <= stat_c;
                `ADSG_ADDR_LATCH_C: RDATA_O <= latch_c_q;
                `ADSG_ADDR_SOFT_INT: RDATA_O <= {SOFT_INT_O, 7'h00};
                `ADSG_ADDR_MASK_B: RDATA_O <= mask_b_q;
                `ADSG_ADDR_MASK_C: RDATA_O <= mask_c_q;
                `ADSG_ADDR_HARD_EN: RDATA_O <= {hard_en_q, 7'h00};
                `ADSG_ADDR_CTRL: RDATA_O <= ctrl_q;
                default: RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    a_read_latch: assert property (RD_I && ADDR_I == `ADSG_ADDR_LATCH_C
        |=> RDATA_O == $past(latch_c_q))
        else $error("latched group c read returned wrong data");

endmodule // adsg_alarm_group

// file: logic/adsg_consts.svh
// Offsets, field positions, reset values and cycle counts of the alarm group.
// Included by the package and the alarm group module; definitions only.
`ifndef ADSG_CONSTS_SVH
`define ADSG_CONSTS_SVH

`define ADSG_ADDR_STAT_B 8'h22
`define ADSG_ADDR_LATCH_B 8'h23
`define ADSG_ADDR_STAT_C 8'h24
`define ADSG_ADDR_LATCH_C 8'h25
`define ADSG_ADDR_SOFT_INT 8'h26
`define ADSG_ADDR_MASK_B 8'h31
`define ADSG_ADDR_MASK_C 8'h32
`define ADSG_ADDR_HARD_EN 8'h33
`define ADSG_ADDR_CTRL 8'h34

// Group b field
`define ADSG_B_LINE_AIS 0
// Group c fields
`define ADSG_C_TX_LOC 7
`define ADSG_C_ADD_LOC 6
`define ADSG_C_DROP_LOC 5
`define ADSG_C_RX_LOC 4
`define ADSG_C_FIFO_ERR 3
`define ADSG_C_NET_ALARM 2
`define ADSG_C_STS_ALARM 1
`define ADSG_C_PATH_AIS 0
// Soft interrupt and hard enable field
`define ADSG_INT_BIT 7
// Control register fields
`define ADSG_CTRL_BSAIS 0
`define ADSG_CTRL_FDAIS 1
`define ADSG_CTRL_ADD_TIMING 2
`define ADSG_CTRL_XRDI 3
`define ADSG_CTRL_RDI 4
`define ADSG_CTRL_EXT_ACT 5

`define ADSG_RST_BYTE 8'h00

// Stuck-clock limits, in RAM clock cycles, inside the allowed windows
`define ADSG_LOC_LIMIT_BUS 6'd20
`define ADSG_LOC_LIMIT_RX 6'd20
// Most zeros in a frame period that still counts as AIS
`define ADSG_AIS_MAX_ZEROS 3'd5

`endif

// file: logic/adsg_pkg.sv
// Types shared by the alarm group: pin bundle and AIS detector states.
// Assumes adsg_consts.svh is on the include path.
`include "adsg_consts.svh"

package adsg_pkg;

    typedef struct packed {
        logic tx_line_clock;
        logic add_bus_clock;
        logic drop_bus_clock;
        logic rx_line_clock;
        logic network_alarm_pin;
        logic external_sts_alarm_pin;
        logic external_path_ais_pin;
    } adsg_pins_s;

    typedef struct packed {
        logic fifo_overflow;
        logic fifo_underflow;
    } adsg_fifo_s;

    typedef enum logic [2:0] {
        AIS_OFF = 3'b001,
        AIS_CLEAR = 3'b010,
        AIS_DECLARED = 3'b100
    } adsg_ais_e;

endpackage
